// >>> design/sdf_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          decimation filter controller.
// Assumes: 32-bit register port with 4-bit byte address.
// Notes:   Included by its bare name.
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

`define SDF_MODE_OFS       4'h0
`define SDF_STATUS_OFS     4'h4
`define SDF_RESULT_OFS     4'h8

`define SDF_RATE_LSB       0
`define SDF_RATE_MSB       9
`define SDF_NOTCH_BIT      10
`define SDF_ZL_BIT         11
`define SDF_ORDER3_BIT     12
`define SDF_CHOP_BIT       13
`define SDF_SEQ_BIT        14

`define SDF_RATE_RST       10'h060
`define SDF_RATE_MIN       10'h001
`define SDF_BASE_LOW       10'h3FF
`define SDF_ORDER3_LAST    2'h2
`define SDF_ORDER4_LAST    2'h3

`endif

// >>> design/sdf_pkg.sv
// Purpose: Types of the decimation filter controller.
// Assumes: Constants live in sdf_consts.svh.
// Notes:   Nothing here is imported; users write sdf_pkg::name.
`default_nettype none
package sdf_pkg;

    typedef enum logic [1:0] {
        SDF_RESET  = 2'b00,
        SDF_SETTLE = 2'b01,
        SDF_RUN    = 2'b11
    } sdf_fsm_t;

    typedef struct packed {
        logic [9:0] rate;
        logic       notch;
        logic       zl;
        logic       order3;
        logic       chop;
        logic       seq;
    } sdf_mode_t;

    typedef struct packed {
        sdf_mode_t   mode;
        sdf_fsm_t    fsm;
        logic [19:0] tick;
        logic [1:0]  sub;
        logic        pol;
        logic [23:0] prev;
        logic [23:0] result;
        logic        valid;
        logic [31:0] rdata;
    } sdf_state_t;

endpackage

`default_nettype wire

// >>> design/sdf_ctrl.sv
// Purpose: Decimation filter controller: output timing, settling, chop.
// Assumes: mclk_tick_in pulses once per modulator master clock cycle;
//          filt_data_in holds the sinc output at every filter boundary.
// Notes:   ce_in low freezes all state, register accesses included; the result strobe drops.
//
// Overview of operation
// - Mode bit set selects the third-order sinc instead of fourth-order.
// - Plain mode: one output per 1024 times divider clocks, divider 1-1023.
// - Channel change resets modulator; first result after three periods for third-order, four for fourth-order.
// - Single channel step: keep converting, settled three or four later.
// - Mode bit 11 written as one enables zero latency.
// - Zero latency gives every conversion full settling, constant time.
// - Enabled channel sequencer forces zero latency operation.
// - Third-order zero latency outputs once per three times 1024 divider.
// - Zero latency: an asynchronous step gives one unsettled result only.
// - Sixty hertz notch bit with divider 96 gives 50 and 60 Hz notches.
// - Chop alternates polarity, one settled conversion each, averages.
// - Chop fourth-order outputs once per four times 1024 divider clocks.
// - Chop fourth-order settles in two periods; first result withheld.
// - Chop step: settled two conversions later, or three mid-conversion.
// - Reset selects fourth-order filter with chop disabled.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "sdf_consts.svh"
`default_nettype none

module sdf_ctrl (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        mclk_tick_in,
    input  wire logic        chan_change_in,
    input  wire logic [23:0] filt_data_in,
    output logic             mod_reset_out,
    output logic             chop_swap_out,
    output logic             third_order_filter_select_out,
    output logic             sixty_hz_notch_enable_out,
    output logic      [9:0]  rate_divider_word_out,
    output logic      [23:0] result_data_out,
    output logic             result_valid_out
);

    sdf_pkg::sdf_state_t s;
    sdf_pkg::sdf_state_t next_s;

    logic        zl_eff;
    logic [1:0]  order_last;
    logic        boundary;
    logic        phase_end;
    logic [24:0] samp_ext;
    logic [24:0] samp_pol;
    logic [24:0] avg_sum;
    logic [9:0]  wr_rate;
    logic [9:0]  rate_m1;

    // The sequencer overrides the zero latency bit.
    assign zl_eff = s.mode.zl | s.mode.seq;

    assign order_last = s.mode.order3 ? `SDF_ORDER3_LAST
                                      : `SDF_ORDER4_LAST;

    // A filter boundary falls every 1024 times divider master clocks; the
    // tick count compares against divider minus one and ten ones, which
    // avoids a multiplier. The divider is never zero, so this cannot wrap.
    assign rate_m1   = s.mode.rate - 10'h001;
    assign boundary  = mclk_tick_in
                       && (s.tick == {rate_m1, `SDF_BASE_LOW});
    assign phase_end = boundary && (s.sub == order_last);

    assign samp_ext = {filt_data_in[23], filt_data_in};
    // In the swapped phase the input is inverted, so negating realigns it.
    assign samp_pol = s.pol ? (25'h000_0000 - samp_ext) : samp_ext;
    assign avg_sum  = {s.prev[23], s.prev} + samp_pol;

    // A divider of zero is out of range and is taken as one.
    assign wr_rate = (wdata_in[`SDF_RATE_MSB:`SDF_RATE_LSB] == 10'h000)
                     ? `SDF_RATE_MIN
                     : wdata_in[`SDF_RATE_MSB:`SDF_RATE_LSB];

    always_comb begin
        next_s       = s;
        next_s.valid = 1'b0;
        if (ce_in) begin
            if (rd_in) begin
                case (addr_in)
                    `SDF_MODE_OFS: begin
                        next_s.rdata = {17'h0_0000,
                                        s.mode.seq, s.mode.chop,
                                        s.mode.order3, s.mode.zl,
                                        s.mode.notch, s.mode.rate};
                    end
                    `SDF_STATUS_OFS: begin
                        next_s.rdata = {24'h00_0000, 2'h0, s.sub,
                                        zl_eff, s.pol, s.fsm};
                    end
                    `SDF_RESULT_OFS: begin
                        next_s.rdata = {8'h00, s.result};
                    end
                    default: begin
                        next_s.rdata = 32'h0000_0000;
                    end
                endcase
            end

            case (s.fsm)
                sdf_pkg::SDF_RESET: begin
                    // Modulator and filter held in reset for this cycle.
                    next_s.fsm  = sdf_pkg::SDF_SETTLE;
                    next_s.tick = 20'h0_0000;
                    next_s.sub  = 2'h0;
                    next_s.pol  = 1'b0;
                end
                sdf_pkg::SDF_SETTLE, sdf_pkg::SDF_RUN: begin
                    if (mclk_tick_in) begin
                        next_s.tick = s.tick + 20'h0_0001;
                    end
                    if (boundary) begin
                        next_s.tick = 20'h0_0000;
                        next_s.sub  = phase_end ? 2'h0
                                                : s.sub + 2'h1;
                    end
                    if (s.mode.chop) begin
                        // Each polarity gets a full settling of the sinc,
                        // so an output comes every order boundaries.
                        if (phase_end) begin
                            next_s.pol  = ~s.pol;
                            next_s.prev = samp_pol[23:0];
                            if (s.fsm == sdf_pkg::SDF_RUN) begin
                                next_s.result = avg_sum[24:1];
                                next_s.valid  = 1'b1;
                            end else begin
                                // First phase after reset is withheld.
                                next_s.fsm = sdf_pkg::SDF_RUN;
                            end
                        end
                    end else if (zl_eff) begin
                        // Every output is a fully settled conversion, so
                        // the rate is divided by the filter order.
                        if (phase_end) begin
                            next_s.result = filt_data_in;
                            next_s.valid  = 1'b1;
                            next_s.fsm    = sdf_pkg::SDF_RUN;
                        end
                    end else if (s.fsm == sdf_pkg::SDF_RUN) begin
                        // Once settled, each boundary is an output; a step
                        // shows only through the filter history.
                        if (boundary) begin
                            next_s.result = filt_data_in;
                            next_s.valid  = 1'b1;
                        end
                    end else if (phase_end) begin
                        next_s.result = filt_data_in;
                        next_s.valid  = 1'b1;
                        next_s.fsm    = sdf_pkg::SDF_RUN;
                    end
                end
                default: begin
                    next_s.fsm = sdf_pkg::SDF_RESET;
                end
            endcase

            // A mode change invalidates the filter history just as a
            // channel change does, so both restart the settling.
            if (wr_in && (addr_in == `SDF_MODE_OFS)) begin
                next_s.mode.rate   = wr_rate;
                next_s.mode.notch  = wdata_in[`SDF_NOTCH_BIT];
                next_s.mode.zl     = wdata_in[`SDF_ZL_BIT];
                next_s.mode.order3 = wdata_in[`SDF_ORDER3_BIT];
                next_s.mode.chop   = wdata_in[`SDF_CHOP_BIT];
                next_s.mode.seq    = wdata_in[`SDF_SEQ_BIT];
            end
            // A result finishing in the restart cycle belongs to the old
            // settings or channel, so it is dropped and the data kept.
            if ((wr_in && (addr_in == `SDF_MODE_OFS)) || chan_change_in) begin
                next_s.fsm    = sdf_pkg::SDF_RESET;
                next_s.result = s.result;
                next_s.valid  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s.mode.rate   <= `SDF_RATE_RST;
            s.mode.notch  <= 1'b0;
            s.mode.zl     <= 1'b0;
            s.mode.order3 <= 1'b0;
            s.mode.chop   <= 1'b0;
            s.mode.seq    <= 1'b0;
            s.fsm         <= sdf_pkg::SDF_RESET;
            s.tick        <= 20'h0_0000;
            s.sub         <= 2'h0;
            s.pol         <= 1'b0;
            s.prev        <= 24'h00_0000;
            s.result      <= 24'h00_0000;
            s.valid       <= 1'b0;
            s.rdata       <= 32'h0000_0000;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_out                     = s.rdata;
    assign mod_reset_out                 = (s.fsm == sdf_pkg::SDF_RESET);
    assign chop_swap_out                 = s.pol;
    assign third_order_filter_select_out = s.mode.order3;
    assign sixty_hz_notch_enable_out     = s.mode.notch;
    assign rate_divider_word_out         = s.mode.rate;
    assign result_data_out               = s.result;
    assign result_valid_out              = s.valid;

endmodule // sdf_ctrl

`default_nettype wire

// >>> design/sdf_ctrl_dummy_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> bench/sdf_mod_model.sv
// Purpose: Modulator side of the filter controller: master clock ticks
//          and a constant sinc output that follows the chop polarity.
// Assumes: One tick per clock, or one every other clock when slow_in.
// Notes:   The offset stays put when inputs swap, so chop must cancel it.
`timescale 1ns/10ps
`default_nettype none
module sdf_mod_model #(
    parameter logic [23:0] SIG = 24'h10_0000,
    parameter logic [23:0] OFS = 24'h00_0100
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        slow_in,
    input  wire logic        swap_in,
    output logic             tick_out,
    output logic      [23:0] data_out
);
    logic ph;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) ph <= 1'b0;
        else ph <= ~ph;
    end
    assign tick_out = rst_b_in && (!slow_in || ph);
    // Swapped inputs arrive negated; the offset is what chop has to remove.
    assign data_out = (swap_in ? -SIG : SIG) + OFS;
endmodule // sdf_mod_model
`default_nettype wire

// >>> bench/sdf_ctrl_assertions.sv
// Purpose: Port-level checks of the decimation filter controller.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Bound into every instance of the controller.
`timescale 1ns/10ps
`default_nettype none
module sdf_ctrl_chk (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        ce_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        mclk_tick_in,
    input wire logic        chan_change_in,
    input wire logic        mod_reset_out,
    input wire logic        chop_swap_out,
    input wire logic        third_order_filter_select_out,
    input wire logic        sixty_hz_notch_enable_out,
    input wire logic [9:0]  rate_divider_word_out,
    input wire logic [23:0] result_data_out,
    input wire logic        result_valid_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [31:0] wd_q;
    always_ff @(posedge clk_in) wd_q <= wdata_in;
    sequence s_mode_wr; ce_in && wr_in && addr_in == 4'h0; endsequence
    sequence s_quiet; !result_valid_out [*8]; endsequence
    property p_sel; s_mode_wr |=> third_order_filter_select_out == wd_q[12];
    endproperty
    property p_notch; s_mode_wr |=> sixty_hz_notch_enable_out == wd_q[10];
    endproperty
    property p_rate; s_mode_wr |=> rate_divider_word_out ==
        ((wd_q[9:0] == 10'h000) ? 10'h001 : wd_q[9:0]); endproperty
    property p_restart; s_mode_wr |=> mod_reset_out; endproperty
    property p_chan; ce_in && chan_change_in |=> mod_reset_out; endproperty
    property p_quiet; mod_reset_out |=> s_quiet; endproperty
    property p_pulse; result_valid_out |=> !result_valid_out; endproperty
    property p_tick; $rose(result_valid_out) |-> $past(mclk_tick_in);
    endproperty
    property p_hold; $changed(result_data_out) |->
        result_valid_out || mod_reset_out; endproperty
    property p_swap; $changed(chop_swap_out) |->
        $past(mclk_tick_in) || mod_reset_out || $past(mod_reset_out);
    endproperty
    a_sel: assert property (p_sel) else $error("order select wrong");
    a_notch: assert property (p_notch) else $error("notch wrong");
    a_rate: assert property (p_rate) else $error("divider wrong");
    a_restart: assert property (p_restart) else $error("no restart");
    a_chan: assert property (p_chan) else $error("no reset");
    a_quiet: assert property (p_quiet) else $error("early result");
    a_pulse: assert property (p_pulse) else $error("long strobe");
    a_tick: assert property (p_tick) else $error("result off tick");
    a_hold: assert property (p_hold) else $error("data moved");
    a_swap: assert property (p_swap) else $error("swap off tick");
endmodule // sdf_ctrl_chk
bind sdf_ctrl sdf_ctrl_chk sdf_ctrl_chk_inst (.clk_in, .rst_b_in, .ce_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .mclk_tick_in,
    .chan_change_in, .mod_reset_out, .chop_swap_out,
    .third_order_filter_select_out, .sixty_hz_notch_enable_out,
    .rate_divider_word_out, .result_data_out, .result_valid_out);
`default_nettype wire

// >>> bench/sdf_ctrl_test.sv
// Purpose: Self-checking bench of the decimation filter controller.
// Assumes: Dividers 1 and 2 keep every output period a few thousand clocks.
// Notes:   First-result timing gets a few clocks of slack for restart.
`timescale 1ns/10ps
`default_nettype none
module sdf_ctrl_test;
    localparam logic [23:0] D = 24'h10_0000;
    localparam logic [23:0] O = 24'h00_0100;
    logic        clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, slow = 1'b0;
    logic        wr_in = 1'b0, rd_in = 1'b0, chan_change_in = 1'b0;
    logic [3:0]  addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0000_0000, rdata_out;
    logic        mclk_tick_in, mod_reset_out, chop_swap_out, result_valid_out;
    logic        third_order_filter_select_out, sixty_hz_notch_enable_out;
    logic [9:0]  rate_divider_word_out;
    logic [23:0] filt_data_in, result_data_out;
    int          error_cnt = 0;
    int          check_count = 0;
    always #2 clk_in = ~clk_in;
    sdf_mod_model #(.SIG(D), .OFS(O)) sdf_mod_model_inst (.clk_in, .rst_b_in,
        .slow_in(slow), .swap_in(chop_swap_out), .tick_out(mclk_tick_in),
        .data_out(filt_data_in));
    sdf_ctrl sdf_ctrl_inst (.clk_in, .rst_b_in, .ce_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .mclk_tick_in, .chan_change_in,
        .filt_data_in, .mod_reset_out, .chop_swap_out,
        .third_order_filter_select_out, .sixty_hz_notch_enable_out,
        .rate_divider_word_out, .result_data_out, .result_valid_out);
    task automatic chk(input logic ok, input string s);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        @(negedge clk_in);
        chk(rdata_out === e, "read data");
    endtask
    // The strobe is looked at on the falling edge, where it has settled.
    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (result_valid_out !== 1'b1 && n < 20000);
    endtask
    // Restart, then time the first result and the gap to the next one.
    task automatic run(input logic [31:0] m, input int f, input int p,
                       input logic [23:0] e);
        int n;
        bus(1'b1, 4'h0, m);
        wait_valid(n);
        chk(n >= f - 4 && n <= f + 8, "first result timing");
        chk(result_data_out === e, "result value");
        wait_valid(n);
        chk(n == p, "output period");
    endtask
    task automatic t_regs();
        rd(4'h0, 32'h0000_0060);
        chk(third_order_filter_select_out === 1'b0, "order at reset");
        rd(4'hC, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0000_0400);
        rd(4'h0, 32'h0000_0401);
        bus(1'b1, 4'h0, 32'h0000_0460);
        @(negedge clk_in);
        chk(sixty_hz_notch_enable_out === 1'b1, "notch");
        chk(rate_divider_word_out === 10'h060, "divider");
    endtask
    task automatic t_chan();
        int n;
        @(posedge clk_in);
        chan_change_in <= 1'b1;
        @(posedge clk_in);
        chan_change_in <= 1'b0;
        wait_valid(n);
        chk(n >= 3068 && n <= 3080, "settling after channel change");
    endtask
    // A reset in mid-run must bring back the default filter settings.
    task automatic t_reset();
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk(mod_reset_out === 1'b1, "restart in reset");
        chk(result_valid_out === 1'b0, "strobe in reset");
        chk(chop_swap_out === 1'b0, "swap in reset");
        chk(third_order_filter_select_out === 1'b0, "order reset");
        chk(rate_divider_word_out === 10'h060, "divider reset");
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(4'h4, 32'h0000_0001);
        rd(4'h0, 32'h0000_0060);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        run(32'h0000_1001, 3072, 1024, D + O);
        t_chan();
        run(32'h0000_1002, 6144, 2048, D + O);
        run(32'h0000_1801, 3072, 3072, D + O);
        run(32'h0000_0801, 4096, 4096, D + O);
        slow <= 1'b1;
        run(32'h0000_5001, 6144, 6144, D + O);
        slow <= 1'b0;
        t_reset();
        run(32'h0000_2001, 8192, 4096, D);
        finish_test();
    end
    initial begin
        #400_000;
        error_cnt++;
        finish_test();
    end
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
endmodule // sdf_ctrl_test
`default_nettype wire
